//--- shared/drive_ctl_pkg.sv
// Shared constants and types for the drive cyclic control/status block
package drive_ctl_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WORD_OFS     = 8'h00;
  localparam logic [7:0] REPORT_WORD_OFS  = 8'h04;
  localparam logic [7:0] TELEGRAM_OFS     = 8'h08;
  localparam logic [7:0] PULSE_LOC0_OFS   = 8'h0c;
  localparam logic [7:0] PULSE_LOC1_OFS   = 8'h10;
  localparam logic [7:0] TOLERANCE_OFS    = 8'h14;
  localparam logic [7:0] MODE_OFS         = 8'h18;
  localparam logic [7:0] CONFIG_OFS       = 8'h1c;
  localparam logic [7:0] ERR_COUNT_OFS    = 8'h20;
  localparam logic [7:0] IRQ_STATUS_OFS   = 8'h24;
  localparam logic [7:0] IRQ_ENABLE_OFS   = 8'h28;
  localparam logic [7:0] IRQ_CLEAR_OFS    = 8'h2c;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [15:0] TOLERANCE_RST   = 16'h0001;
  localparam logic [15:0] TOLERANCE_OFF   = 16'hffff;
  localparam logic [15:0] MODE_SPEED_NORG = 16'h0003;
  localparam logic [15:0] TELEGRAM_RST    = 16'h0003;
  localparam logic [15:0] TELEGRAM_FREE   = 16'h03e7;
  localparam logic [15:0] PULSE_WORD_NUM  = 16'h0001;
  localparam logic [15:0] PULSE_BIT_POS   = 16'h000b;

  // Config register fields
  localparam int CFG_CTRL_BIT_POS  = 0;
  localparam int CFG_BRAKE_ACT_POS = 1;
  localparam int CFG_BRAKE_SEL_POS = 2;
  localparam int CFG_POSITIONER    = 3;

  // Interrupt status bits
  localparam int IRQ_LIFE_FAULT = 0;
  localparam int IRQ_NEW_WORD   = 1;
  localparam int IRQ_WIDTH      = 2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic ready_on;
    logic ready;
    logic op_enabled;
    logic jog_active;
    logic drive_ready;
    logic ctrl_enable;
    logic pulses_on;
    logic brake_open;
  } drive_state_t;

  typedef struct packed {
    logic switch_on;
    logic coast_stop;
    logic quick_stop;
    logic enable_op;
    logic enable_ramp;
    logic continue_ramp;
    logic enable_setpoint;
    logic open_brake;
    logic jog1;
    logic jog2;
    logic plc_control;
    logic enable_speed_ctl;
    logic close_brake;
  } drive_cmd_t;

endpackage : drive_ctl_pkg

//--- core/drive_cyclic_control_status.sv
// Cyclic control/status word handling with sign-of-life monitoring
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module drive_cyclic_control_status (
  // Clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        arst_n_i,
  // Register port
  input  wire drive_ctl_pkg::reg_req_t     req_i,
  output logic [31:0]                      rdata_o,
  // Cyclic link from controller
  input  wire logic                        cycle_strobe_i,
  input  wire logic [15:0]                 cmd_word_i,
  input  wire logic [15:0]                 life_word_i,
  input  wire logic [15:0]                 telegram_i,
  // Drive state in
  input  wire drive_ctl_pkg::drive_state_t state_i,
  // Decoded commands and report out
  output drive_ctl_pkg::drive_cmd_t        cmd_o,
  output logic                             brake_close_o,
  output logic [15:0]                      report_word_o,
  output logic                             report_valid_o,
  output logic                             life_fault_o,
  output logic                             irq_o
);
  import drive_ctl_pkg::*;

  logic [15:0]          cmd_word_r;
  logic [15:0]          report_r;
  logic [15:0]          telegram_r;
  logic [15:0]          tolerance_r;
  logic [15:0]          err_count_r;
  logic [15:0]          err_count_nxt;
  logic [3:0]           life_prev_r;
  logic                 life_seen_r;
  logic [3:0]           config_r;
  logic [IRQ_WIDTH-1:0] irq_status_r;
  logic [IRQ_WIDTH-1:0] irq_enable_r;
  logic [IRQ_WIDTH-1:0] irq_set;
  logic                 report_valid_r;
  logic                 fault_pulse;
  logic                 life_bad;
  logic                 monitor_on;
  logic                 coast_req;
  logic                 quick_req;
  logic                 inhibit;
  logic [15:0]          report_nxt;
  logic                 telegram_ok;

  // ----------------------------------------------------------------
  // Command word capture
  // ----------------------------------------------------------------
  // latch received word
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_word_r <= 16'h0000;
    end else if (cycle_strobe_i) begin
      cmd_word_r <= cmd_word_i;
    end
  end

  // Unknown codes keep the previous telegram so the readout stays legal
  always_comb begin
    unique case (telegram_i)
      16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0066, 16'h0067, 16'h0069, 16'h006a:
        telegram_ok = !config_r[CFG_POSITIONER];
      16'h0007, 16'h0009, 16'h006f, 16'h0070, 16'h0071, TELEGRAM_FREE:
        telegram_ok = config_r[CFG_POSITIONER];
      default:
        telegram_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      telegram_r <= TELEGRAM_RST;
    end else if (cycle_strobe_i && telegram_ok) begin
      telegram_r <= telegram_i;
    end
  end

  always_comb begin
    cmd_o.switch_on        = cmd_word_r[0];
    cmd_o.coast_stop       = !cmd_word_r[1];
    cmd_o.quick_stop       = !cmd_word_r[2];
    cmd_o.enable_op        = cmd_word_r[3];
    cmd_o.enable_ramp      = cmd_word_r[4];
    cmd_o.continue_ramp    = cmd_word_r[5];
    cmd_o.enable_setpoint  = cmd_word_r[6];
    cmd_o.open_brake       = cmd_word_r[7];
    cmd_o.jog1             = cmd_word_r[8];
    cmd_o.jog2             = cmd_word_r[9];
    cmd_o.plc_control      = config_r[CFG_CTRL_BIT_POS] ? cmd_word_r[10] : 1'b1;
    cmd_o.enable_speed_ctl = cmd_word_r[12];
    cmd_o.close_brake      = cmd_word_r[14];
  end

  // ----------------------------------------------------------------
  // Status word assembly
  // ----------------------------------------------------------------
  // Stops come from the word being taken, so the report never lags a frame
  assign coast_req = !cmd_word_i[1];
  assign quick_req = !cmd_word_i[2];
  // Switch-on stays inhibited while any stop is requested
  assign inhibit   = coast_req || quick_req || !state_i.ready_on;

  always_comb begin
    report_nxt     = 16'h0000;
    report_nxt[0]  = state_i.ready_on;
    report_nxt[1]  = state_i.ready;
    report_nxt[2]  = state_i.op_enabled;
    report_nxt[3]  = state_i.jog_active;
    report_nxt[4]  = !coast_req;
    report_nxt[5]  = !quick_req;
    report_nxt[6]  = inhibit;
    report_nxt[7]  = state_i.drive_ready;
    report_nxt[8]  = state_i.ctrl_enable;
    report_nxt[9]  = config_r[CFG_CTRL_BIT_POS] ? cmd_word_i[10] : 1'b1;
    report_nxt[11] = state_i.pulses_on;
    report_nxt[12] = state_i.brake_open;
    report_nxt[13] = cmd_word_i[14] || !state_i.pulses_on;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      report_r       <= 16'h0000;
      report_valid_r <= 1'b0;
    end else begin
      report_valid_r <= cycle_strobe_i;
      if (cycle_strobe_i) begin
        report_r <= report_nxt;
      end
    end
  end

  assign report_word_o  = report_r;
  assign report_valid_o = report_valid_r;

  assign brake_close_o = !(config_r[CFG_BRAKE_ACT_POS] && config_r[CFG_BRAKE_SEL_POS])
                         && report_r[13];

  // ----------------------------------------------------------------
  // Sign-of-life monitor
  // ----------------------------------------------------------------
  // monitoring disabled
  assign monitor_on = (tolerance_r != TOLERANCE_OFF);
  assign life_bad   = life_seen_r && (life_word_i[15:12] != life_prev_r + 4'h1);

  always_comb begin
    err_count_nxt = err_count_r;
    fault_pulse   = 1'b0;
    if (cycle_strobe_i && monitor_on) begin
      if (life_bad) begin
        if (err_count_r != 16'hffff) begin
          err_count_nxt = err_count_r + 16'h0001;
        end
        fault_pulse = (err_count_r == tolerance_r);
      end else begin
        err_count_nxt = 16'h0000;
      end
    end else if (!monitor_on) begin
      err_count_nxt = 16'h0000;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      err_count_r <= 16'h0000;
      life_prev_r <= 4'h0;
      life_seen_r <= 1'b0;
    end else begin
      err_count_r <= err_count_nxt;
      if (cycle_strobe_i) begin
        life_prev_r <= life_word_i[15:12];
        life_seen_r <= 1'b1;
      end
    end
  end

  assign life_fault_o = irq_status_r[IRQ_LIFE_FAULT];

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_set = {cycle_strobe_i, fault_pulse};

  // Set wins over a simultaneous clear so no event is lost
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_status_r <= '0;
    end else if (req_i.wr && req_i.addr == IRQ_CLEAR_OFS) begin
      irq_status_r <= (irq_status_r & ~req_i.wdata[IRQ_WIDTH-1:0]) | irq_set;
    end else begin
      irq_status_r <= irq_status_r | irq_set;
    end
  end

  assign irq_o = |(irq_status_r & irq_enable_r);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tolerance_r  <= TOLERANCE_RST;
      config_r     <= 4'h0;
      irq_enable_r <= '0;
    end else if (req_i.wr) begin
      unique case (req_i.addr)
        TOLERANCE_OFS:  tolerance_r  <= req_i.wdata[15:0];
        CONFIG_OFS:     config_r     <= req_i.wdata[3:0];
        IRQ_ENABLE_OFS: irq_enable_r <= req_i.wdata[IRQ_WIDTH-1:0];
        default:        ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // profile subset in report
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (req_i.rd) begin
      unique case (req_i.addr)
        CMD_WORD_OFS:    rdata_o <= {16'h0000, cmd_word_r[15:11], cmd_o.plc_control,
                                     cmd_word_r[9:0]};
        REPORT_WORD_OFS: rdata_o <= {16'h0000, report_r};
        TELEGRAM_OFS:    rdata_o <= {16'h0000, telegram_r};
        PULSE_LOC0_OFS:  rdata_o <= {16'h0000, PULSE_WORD_NUM};
        PULSE_LOC1_OFS:  rdata_o <= {16'h0000, PULSE_BIT_POS};
        TOLERANCE_OFS:   rdata_o <= {16'h0000, tolerance_r};
        MODE_OFS:        rdata_o <= {16'h0000, MODE_SPEED_NORG};
        CONFIG_OFS:      rdata_o <= {28'h0000000, config_r};
        ERR_COUNT_OFS:   rdata_o <= {16'h0000, err_count_r};
        IRQ_STATUS_OFS:  rdata_o <= {30'h00000000, irq_status_r};
        IRQ_ENABLE_OFS:  rdata_o <= {30'h00000000, irq_enable_r};
        default:         rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  stop_decode_a: assert property (
    cycle_strobe_i |=> cmd_o.coast_stop == !$past(cmd_word_i[1]))
    else $error("coast stop decode wrong");
  switch_on_a: assert property (
    cycle_strobe_i |=> cmd_o.switch_on == $past(cmd_word_i[0]))
    else $error("switch-on decode wrong");
  quick_stop_a: assert property (
    cycle_strobe_i |=> cmd_o.quick_stop == !$past(cmd_word_i[2]))
    else $error("quick stop decode wrong");
  ctrl_hold_a: assert property (
    !config_r[CFG_CTRL_BIT_POS] |-> cmd_o.plc_control)
    else $error("control request not held");
  ctrl_take_a: assert property (
    cycle_strobe_i ##1 config_r[CFG_CTRL_BIT_POS] |-> cmd_o.plc_control == $past(cmd_word_i[10]))
    else $error("control request not taken from word");
  cmd_bits_a: assert property (
    cycle_strobe_i |=> cmd_o.enable_op == $past(cmd_word_i[3])
      && cmd_o.jog2 == $past(cmd_word_i[9]) && cmd_o.close_brake == $past(cmd_word_i[14]))
    else $error("command bits decode wrong");
  cmd_capture_a: assert property (
    cycle_strobe_i |=> cmd_word_r == $past(cmd_word_i))
    else $error("command word not captured");
  report_cycle_a: assert property (
    cycle_strobe_i |=> report_valid_o && report_word_o[4] == !$past(coast_req))
    else $error("report word not updated");
  valid_pulse_a: assert property (
    !cycle_strobe_i |=> !report_valid_o)
    else $error("report valid without strobe");
  new_word_a: assert property (
    cycle_strobe_i |=> irq_status_r[IRQ_NEW_WORD])
    else $error("new word event not latched");
  ready_bits_a: assert property (
    cycle_strobe_i |=> report_word_o[0] == $past(state_i.ready_on)
      && report_word_o[1] == $past(state_i.ready) && report_word_o[2] == $past(state_i.op_enabled))
    else $error("ready bits wrong");
  coast_bits_a: assert property (
    cycle_strobe_i && !cmd_word_i[1] |=> !report_word_o[4] && report_word_o[6])
    else $error("coast stop not reported");
  pulse_bits_a: assert property (
    cycle_strobe_i |=> report_word_o[11] == $past(state_i.pulses_on)
      && report_word_o[12] == $past(state_i.brake_open))
    else $error("pulse or brake bit wrong");
  close_cmd_a: assert property (
    cycle_strobe_i && cmd_word_i[14] |=> report_word_o[13])
    else $error("close brake command not reported");
  brake_override_a: assert property (
    config_r[CFG_BRAKE_ACT_POS] && config_r[CFG_BRAKE_SEL_POS] |-> !brake_close_o)
    else $error("brake driven under safe brake");
  brake_follow_a: assert property (
    !(config_r[CFG_BRAKE_ACT_POS] && config_r[CFG_BRAKE_SEL_POS])
      |-> brake_close_o == report_word_o[13])
    else $error("brake output not following report");
  profile_bit_a: assert property (
    cycle_strobe_i && !config_r[CFG_CTRL_BIT_POS] |=> report_word_o[9])
    else $error("control requested bit wrong");
  telegram_hold_a: assert property (
    !cycle_strobe_i |=> telegram_r == $past(telegram_r))
    else $error("telegram changed without strobe");
  telegram_legal_a: assert property (
    cycle_strobe_i && !telegram_ok |=> telegram_r == $past(telegram_r))
    else $error("illegal telegram taken");
  pulse_loc_a: assert property (
    req_i.rd && req_i.addr == PULSE_LOC1_OFS |=> rdata_o[15:0] == PULSE_BIT_POS)
    else $error("pulse bit location wrong");
  err_step_a: assert property (
    cycle_strobe_i && monitor_on && life_bad && err_count_r < 16'h00ff
      |=> err_count_r == $past(err_count_r) + 16'h0001)
    else $error("error count not incremented");
  err_hold_a: assert property (
    !cycle_strobe_i && monitor_on |=> err_count_r == $past(err_count_r))
    else $error("error count moved without strobe");
  monitor_off_a: assert property (
    !monitor_on |=> err_count_r == 16'h0000)
    else $error("monitor not disabled");
  life_clear_a: assert property (
    cycle_strobe_i && monitor_on && !life_bad |=> err_count_r == 16'h0000)
    else $error("error count not cleared");
  fault_raise_a: assert property (
    fault_pulse |=> irq_status_r[IRQ_LIFE_FAULT])
    else $error("fault not latched");
  fault_edge_a: assert property (
    cycle_strobe_i && monitor_on && life_bad && err_count_r == tolerance_r
      |=> irq_status_r[IRQ_LIFE_FAULT])
    else $error("fault not raised above tolerance");
  mode_read_a: assert property (
    req_i.rd && req_i.addr == MODE_OFS |=> rdata_o[15:0] == MODE_SPEED_NORG)
    else $error("operating mode readout wrong");
  rdata_idle_a: assert property (
    !req_i.rd |=> rdata_o == 32'h0000_0000)
    else $error("read data not idle");

endmodule : drive_cyclic_control_status

//--- test/ctl_model.sv
// Controller-side model that sends one cyclic frame per request
`timescale 1ns/10ps
module ctl_model (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // Frame request from the bench
  input  wire logic        send_i,
  input  wire logic        stale_life_i,
  input  wire logic [15:0] cmd_i,
  input  wire logic [15:0] tel_i,
  // Cyclic words towards the drive
  output logic             strobe_o,
  output logic [15:0]      cmd_word_o,
  output logic [15:0]      life_word_o,
  output logic [15:0]      telegram_o
);
  logic [3:0] life_r;

  // command word each frame, life counter in word four
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strobe_o    <= 1'b0;
      cmd_word_o  <= 16'h0;
      life_word_o <= 16'h0;
      telegram_o  <= 16'h0;
      life_r      <= 4'h0;
    end else if (send_i) begin
      strobe_o    <= 1'b1;
      cmd_word_o  <= cmd_i;
      telegram_o  <= tel_i;
      // A stale counter repeats the last value to provoke an error
      life_word_o <= {(stale_life_i ? life_r : life_r + 4'h1), 12'h000};
      if (!stale_life_i) begin
        life_r <= life_r + 4'h1;
      end
    end else begin
      strobe_o <= 1'b0;
      // Words are not held between frames, so stale sampling shows up
      if (strobe_o) begin
        cmd_word_o  <= ~cmd_word_o;
        life_word_o <= ~life_word_o;
        telegram_o  <= ~telegram_o;
      end
    end
  end
endmodule : ctl_model

//--- test/testbench.sv
// Self-checking bench for the cyclic control/status block
`timescale 1ns/10ps
module testbench;
  import drive_ctl_pkg::*;
  logic         clock_i = 1'b0;
  logic         arst_n_i = 1'b0;
  reg_req_t     req = '0;
  drive_state_t state = '0;
  drive_cmd_t   cmd;
  logic [31:0]  rdata;
  logic         send = 1'b0;
  logic         stale = 1'b0;
  logic [15:0]  cmd_in = 16'h0;
  logic [15:0]  tel_in = 16'h3;
  logic         strobe, brake_close, valid, fault, irq;
  logic [15:0]  cmd_w, life_w, tel_w, report;
  logic [15:0]  std_codes[8] = '{16'h3, 16'h4, 16'h5, 16'h6, 16'h66, 16'h67, 16'h69, 16'h6a};
  logic [15:0]  pos_codes[6] = '{16'h7, 16'h9, 16'h6f, 16'h70, 16'h71, 16'h3e7};
  int           fail_count = 0;
  int           total_checks = 0;
  int           cycles = 0;

  always #12.5 clock_i = ~clock_i;

  drive_cyclic_control_status DUT (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .req_i(req), .rdata_o(rdata),
    .cycle_strobe_i(strobe), .cmd_word_i(cmd_w), .life_word_i(life_w),
    .telegram_i(tel_w), .state_i(state), .cmd_o(cmd), .brake_close_o(brake_close),
    .report_word_o(report), .report_valid_o(valid), .life_fault_o(fault), .irq_o(irq));

  ctl_model partner (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .send_i(send), .stale_life_i(stale),
    .cmd_i(cmd_in), .tel_i(tel_in), .strobe_o(strobe), .cmd_word_o(cmd_w),
    .life_word_o(life_w), .telegram_o(tel_w));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // A hung handshake must not stall the run forever
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    req.rd <= 1'b0;
    #1;
    chk_word(rdata, e);
  endtask : rd_chk

  task automatic send_frame(input logic [15:0] c, input logic [15:0] t, input logic st);
    int n;
    @(posedge clock_i);
    send <= 1'b1;
    cmd_in <= c;
    tel_in <= t;
    stale <= st;
    @(posedge clock_i);
    send <= 1'b0;
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (valid !== 1'b1 && n < 8);
    chk_bit(valid, 1'b1);
  endtask : send_frame

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // fixed readouts, read-only and unmapped places
  task automatic t_reg_map();
    rd_chk(TELEGRAM_OFS, 32'h3);
    rd_chk(PULSE_LOC0_OFS, 32'h1);
    rd_chk(PULSE_LOC1_OFS, 32'hb);
    rd_chk(TOLERANCE_OFS, 32'h1);
    reg_wr(MODE_OFS, 32'h7);
    rd_chk(MODE_OFS, 32'h3);
    rd_chk(8'h30, 32'h0);
    reg_wr(TOLERANCE_OFS, 32'hffff);
    rd_chk(TOLERANCE_OFS, 32'hffff);
    reg_wr(TOLERANCE_OFS, 32'h1);
  endtask : t_reg_map

  task automatic t_commands();
    logic [15:0] cw[4] = '{16'h5fff, 16'h0000, 16'h0000, 16'h0400};
    logic [12:0] e;
    logic        c;
    for (int i = 0; i < 4; i++) begin
      c = (i >= 2);
      reg_wr(CONFIG_OFS, {31'h0, c});
      send_frame(cw[i], 16'h3, 1'b0);
      e = {cw[i][0], ~cw[i][1], ~cw[i][2], cw[i][3], cw[i][4], cw[i][5], cw[i][6], cw[i][7],
           cw[i][8], cw[i][9], (c ? cw[i][10] : 1'b1), cw[i][12], cw[i][14]};
      chk_word({19'h0, cmd}, {19'h0, e});
      rd_chk(CMD_WORD_OFS, {16'h0, cw[i][15:11], e[2], cw[i][9:0]});
    end
  endtask : t_commands

  task automatic t_status(input logic [7:0] s, input logic [15:0] c, input logic [15:0] e);
    @(posedge clock_i);
    state <= drive_state_t'(s);
    send_frame(c, 16'h3, 1'b0);
    chk_word({16'h0, report}, {16'h0, e});
    @(posedge clock_i);
    #1;
    chk_bit(valid, 1'b0);
    rd_chk(REPORT_WORD_OFS, {16'h0, e});
  endtask : t_status

  // safe brake function takes the brake away from the report bit
  task automatic t_brake();
    for (int i = 0; i < 4; i++) begin
      reg_wr(CONFIG_OFS, 32'(i * 2));
      send_frame(16'h4006, 16'h3, 1'b0);
      chk_bit(brake_close, i != 3);
    end
  endtask : t_brake

  // legal codes per variant, illegal code holds
  task automatic t_telegram();
    reg_wr(CONFIG_OFS, 32'h0);
    foreach (std_codes[i]) begin
      send_frame(16'h7, std_codes[i], 1'b0);
      rd_chk(TELEGRAM_OFS, {16'h0, std_codes[i]});
    end
    send_frame(16'h7, 16'h7, 1'b0);
    rd_chk(TELEGRAM_OFS, 32'h6a);
    reg_wr(CONFIG_OFS, 32'h8);
    foreach (pos_codes[i]) begin
      send_frame(16'h7, pos_codes[i], 1'b0);
      rd_chk(TELEGRAM_OFS, {16'h0, pos_codes[i]});
    end
  endtask : t_telegram

  // life-sign errors, fault event and interrupt
  task automatic t_life();
    reg_wr(IRQ_CLEAR_OFS, 32'h3);
    reg_wr(IRQ_ENABLE_OFS, 32'h1);
    send_frame(16'h7, 16'h3, 1'b1);
    rd_chk(ERR_COUNT_OFS, 32'h1);
    chk_bit(fault, 1'b0);
    send_frame(16'h7, 16'h3, 1'b0);
    rd_chk(ERR_COUNT_OFS, 32'h0);
    send_frame(16'h7, 16'h3, 1'b1);
    send_frame(16'h7, 16'h3, 1'b1);
    rd_chk(IRQ_STATUS_OFS, 32'h3);
    chk_bit(fault, 1'b1);
    chk_bit(irq, 1'b1);
    reg_wr(IRQ_ENABLE_OFS, 32'h0);
    #1;
    chk_bit(irq, 1'b0);
    reg_wr(IRQ_CLEAR_OFS, 32'h3);
    rd_chk(IRQ_STATUS_OFS, 32'h0);
    reg_wr(TOLERANCE_OFS, 32'hffff);
    repeat (3) send_frame(16'h7, 16'h3, 1'b1);
    rd_chk(ERR_COUNT_OFS, 32'h0);
    chk_bit(fault, 1'b0);
  endtask : t_life

  initial begin
    repeat (8) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_reg_map();
    t_commands();
    t_status(8'hff, 16'h0007, 16'h19bf);
    t_status(8'h00, 16'h4000, 16'h2040);
    t_status(8'h00, 16'h0400, 16'h2240);
    @(posedge clock_i);
    state <= drive_state_t'(8'hff);
    t_brake();
    t_telegram();
    t_life();
    tally_and_finish();
  end
endmodule : testbench
